// ==== design/tcd_dispatch.sv ====
// Command dispatcher core with its AXI4-Lite register slave.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps

// Operation
// - Initialize keeps RAM, stops any stream
// - Reset initialize restores RAM from saved copy
// - Continuous commands only start a stream
// - Level and binary commands change converter only
// - Group After inquiry: forward before reply
// - Busy After rejects next After, sets error
// - Sequential commands: reply before forwarding
// - Single write enable covers one update
// - Continuous enable holds until plain enable
// - Level command needs analog enable; forms differ
// - Checksum enable persists, binary needs checksum
// - New stream replaces the running stream
// - Enabled string action writes nonvolatile storage
// - RAM changes persist only after store-all
// - Source select steers converter, no write
// - Converter writes only from action forms
// - Power-up mode enables user message emission
// - Enable-gated RAM slow interval threshold
// - Status read reports and clears error
module tcd_dispatch (
   input wire logic sys_clk,
   input wire logic rst,
   input tcd_pkg::tcd_cmd_t cmd,
   output logic cmd_ready,
   input wire logic powerup_evt,
   output tcd_pkg::tcd_reply_t reply,
   output tcd_pkg::tcd_fx_t fx,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   logic [1:0] ctrl_r;
   logic err_r;
   logic [7:0] busy_cnt_r;
   logic busy_r;
   logic stream_on_r;
   logic [1:0] stream_kind_r;
   logic we_single_r;
   logic we_cont_r;
   logic ae_single_r;
   logic ae_pers_r;
   logic ae_cks_r;
   logic [11:0] dac_r;
   // RAM working copy and saved copy, one slot per parameter
   // 0..3 converter range set, 4 threshold, 5 source, 6 power-up mode, 7 other
   logic [15:0] ram_r [8];
   logic [15:0] nv_r [8];
   tcd_pkg::tcd_reply_t reply_r;
   tcd_pkg::tcd_fx_t fx_r;

   logic take;
   logic is_after;
   logic is_before;
   logic ram_upd;
   logic ram_ok;
   logic analog_ok;
   logic reject;
   logic [2:0] slot;

   assign cmd_ready = ctrl_r[tcd_pkg::CTRL_CMD_EN_BIT];
   assign take = cmd.valid & cmd_ready;

   // Command classification
   always_comb begin
      is_after = 1'b0;
      is_before = 1'b0;
      ram_upd = 1'b0;
      slot = 3'h7;
      case (cmd.code)
         tcd_pkg::CMD_CONT_P_TXT,
         tcd_pkg::CMD_CONT_P_BIN,
         tcd_pkg::CMD_CONT_T_C,
         tcd_pkg::CMD_CONT_T_F,
         tcd_pkg::CMD_ANALOG_LEVEL,
         tcd_pkg::CMD_INFO_AFTER: begin
            is_after = 1'b1;
         end
         tcd_pkg::CMD_STRING: begin
            is_after = 1'b1;
            ram_upd = cmd.action;
         end
         tcd_pkg::CMD_PARAM_AFTER: begin
            is_after = 1'b1;
            ram_upd = cmd.action;
         end
         tcd_pkg::CMD_ANALOG_CFG: begin
            is_after = 1'b1;
            ram_upd = cmd.action;
            slot = {1'b0, cmd.sel};
         end
         tcd_pkg::CMD_SLOW_THR: begin
            is_before = 1'b1;
            ram_upd = cmd.action;
            slot = 3'h4;
         end
         tcd_pkg::CMD_SRC_SEL: begin
            is_before = 1'b1;
            ram_upd = cmd.action;
            slot = 3'h5;
         end
         tcd_pkg::CMD_POWERUP_MODE: begin
            is_before = 1'b1;
            ram_upd = cmd.action;
            slot = 3'h6;
         end
         tcd_pkg::CMD_PARAM_BEFORE: begin
            is_before = 1'b1;
            ram_upd = cmd.action;
         end
         tcd_pkg::CMD_READ_STATUS: begin
            is_before = 1'b1;
         end
         tcd_pkg::CMD_STORE_ALL: begin
            ram_upd = 1'b1;
         end
         default: begin
            is_after = 1'b0;
         end
      endcase
   end

   // Enable checks; strings need the single form, not the continuous one
   always_comb begin
      if (cmd.code == tcd_pkg::CMD_STRING) begin
         ram_ok = we_single_r & ~we_cont_r;
      end else begin
         ram_ok = we_single_r | we_cont_r;
      end
      analog_ok = ae_single_r | ae_pers_r | ae_cks_r;
      if (cmd.code == tcd_pkg::CMD_DAC_BIN && ae_cks_r && !cmd.cks_ok) begin
         analog_ok = 1'b0;
      end
   end

   always_comb begin
      reject = 1'b0;
      if (is_after && busy_r) begin
         reject = 1'b1;
      end else if (ram_upd && !ram_ok) begin
         reject = 1'b1;
      end else if (cmd.action && !analog_ok &&
                   (cmd.code == tcd_pkg::CMD_ANALOG_LEVEL ||
                    cmd.code == tcd_pkg::CMD_DAC_BIN)) begin
         reject = 1'b1;
      end
   end

   // Error flag: a new rejection wins over the status-read clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         err_r <= 1'b0;
      end else if (take && reject) begin
         err_r <= 1'b1;
      end else if (take && cmd.code == tcd_pkg::CMD_READ_STATUS) begin
         err_r <= 1'b0;
      end
   end

   // After-type execution window
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy_r <= 1'b0;
         busy_cnt_r <= 8'h00;
      end else if (take && is_after && !reject) begin
         busy_r <= 1'b1;
         busy_cnt_r <= tcd_pkg::AFTER_EXEC_LAST;
      end else if (busy_r) begin
         if (busy_cnt_r == 8'h00) begin
            busy_r <= 1'b0;
         end else begin
            busy_cnt_r <= busy_cnt_r - 8'h01;
         end
      end
   end

   // Write enables for RAM updates
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         we_single_r <= 1'b0;
         we_cont_r <= 1'b0;
      end else if (take) begin
         if (cmd.code == tcd_pkg::CMD_WE) begin
            we_single_r <= 1'b1;
            we_cont_r <= 1'b0;
         end else if (cmd.code == tcd_pkg::CMD_WE_RAM) begin
            we_cont_r <= 1'b1;
         end else if (ram_upd) begin
            we_single_r <= 1'b0;
         end
      end
   end

   // Analog enables
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ae_single_r <= 1'b0;
         ae_pers_r <= 1'b0;
         ae_cks_r <= 1'b0;
      end else if (take) begin
         case (cmd.code)
            tcd_pkg::CMD_AE: begin
               ae_single_r <= 1'b1;
               ae_pers_r <= 1'b0;
               ae_cks_r <= 1'b0;
            end
            tcd_pkg::CMD_AE_PERSIST: begin
               ae_pers_r <= 1'b1;
               ae_cks_r <= 1'b0;
            end
            tcd_pkg::CMD_AE_CKS: begin
               ae_cks_r <= 1'b1;
               ae_pers_r <= 1'b0;
            end
            tcd_pkg::CMD_ANALOG_LEVEL,
            tcd_pkg::CMD_DAC_BIN: begin
               if (cmd.action) begin
                  ae_single_r <= 1'b0;
               end
            end
            default: begin
               ae_single_r <= ae_single_r;
            end
         endcase
      end
   end

   // RAM parameters and their saved copies, one process per slot
   for (genvar i = 0; i < 8; i++) begin : g_param
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            ram_r[i] <= tcd_pkg::PARAM_RESET;
            nv_r[i] <= tcd_pkg::PARAM_RESET;
         end else if (take && !reject) begin
            if (cmd.code == tcd_pkg::CMD_STORE_ALL) begin
               nv_r[i] <= ram_r[i];
            end else if (cmd.code == tcd_pkg::CMD_INIT_RESET) begin
               ram_r[i] <= nv_r[i];
            end else if (ram_upd && slot == 3'(i) &&
                         cmd.code != tcd_pkg::CMD_STRING) begin
               ram_r[i] <= cmd.value;
            end
         end
      end
   end

   // Continuous reading stream state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stream_on_r <= 1'b0;
         stream_kind_r <= 2'h0;
      end else if (take && !reject) begin
         case (cmd.code)
            tcd_pkg::CMD_INIT,
            tcd_pkg::CMD_INIT_RESET: begin
               stream_on_r <= 1'b0;
            end
            tcd_pkg::CMD_CONT_P_TXT,
            tcd_pkg::CMD_CONT_P_BIN,
            tcd_pkg::CMD_CONT_T_C,
            tcd_pkg::CMD_CONT_T_F: begin
               stream_on_r <= 1'b1;
               stream_kind_r <= cmd.code[1:0] - 2'h2;
            end
            default: begin
               stream_on_r <= stream_on_r;
            end
         endcase
      end
   end

   // Converter level; source select alone never writes it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dac_r <= tcd_pkg::DAC_RESET;
      end else if (take && !reject && cmd.action &&
                   (cmd.code == tcd_pkg::CMD_ANALOG_LEVEL ||
                    cmd.code == tcd_pkg::CMD_DAC_BIN)) begin
         dac_r <= cmd.value[11:0];
      end
   end

   // Effect pulses toward converter, storage and streams
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fx_r <= '0;
      end else begin
         fx_r <= '0;
         fx_r.dac_val <= fx_r.dac_val;
         fx_r.stream_kind <= stream_kind_r;
         if (powerup_evt && ram_r[6][0] && ctrl_r[tcd_pkg::CTRL_MSG_EN_BIT]) begin
            fx_r.powerup_msg <= 1'b1;
         end
         if (take && !reject) begin
            case (cmd.code)
               tcd_pkg::CMD_INIT: begin
                  fx_r.stream_stop <= stream_on_r;
               end
               tcd_pkg::CMD_INIT_RESET: begin
                  fx_r.stream_stop <= stream_on_r;
                  fx_r.nv_restore <= 1'b1;
               end
               tcd_pkg::CMD_CONT_P_TXT,
               tcd_pkg::CMD_CONT_P_BIN,
               tcd_pkg::CMD_CONT_T_C,
               tcd_pkg::CMD_CONT_T_F: begin
                  fx_r.stream_stop <= stream_on_r;
                  fx_r.stream_start <= 1'b1;
                  fx_r.stream_kind <= cmd.code[1:0] - 2'h2;
               end
               tcd_pkg::CMD_ANALOG_LEVEL,
               tcd_pkg::CMD_DAC_BIN: begin
                  fx_r.dac_wr <= cmd.action;
                  fx_r.dac_val <= cmd.value[11:0];
               end
               tcd_pkg::CMD_ANALOG_CFG: begin
                  fx_r.dac_wr <= cmd.action;
                  fx_r.dac_val <= dac_r;
               end
               tcd_pkg::CMD_STRING: begin
                  fx_r.nv_string_wr <= cmd.action;
                  fx_r.string_sel <= cmd.sel;
                  fx_r.string_val <= cmd.value;
               end
               tcd_pkg::CMD_STORE_ALL: begin
                  fx_r.nv_store_all <= 1'b1;
               end
               default: begin
                  fx_r.dac_wr <= 1'b0;
               end
            endcase
         end
      end
   end

   // Reply descriptor and ordering for group or global addresses
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reply_r <= '0;
      end else begin
         reply_r.valid <= take;
         reply_r.rejected <= take & reject;
         reply_r.data <= (cmd.code == tcd_pkg::CMD_READ_STATUS) ?
                         {15'h0000, err_r | reject} : cmd.value;
         if (!cmd.multi) begin
            reply_r.order <= tcd_pkg::ORD_NONE;
         end else if (is_after) begin
            reply_r.order <= tcd_pkg::ORD_FWD_FIRST;
         end else if (is_before) begin
            reply_r.order <= tcd_pkg::ORD_REPLY_FIRST;
         end else begin
            reply_r.order <= tcd_pkg::ORD_NONE;
         end
      end
   end

   assign reply = reply_r;
   assign fx = fx_r;

   // AXI4-Lite slave: address and data taken in either order
   logic aw_have_r;
   logic w_have_r;
   logic [3:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [31:0] rd_word;

   assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tcd_pkg::RESP_OKAY;
         ctrl_r <= tcd_pkg::CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_have_r && w_have_r) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= tcd_pkg::RESP_OKAY;
            if (aw_addr_r[3:2] == tcd_pkg::OFF_CTRL[3:2]) begin
               if (w_strb_r[0]) begin
                  ctrl_r <= w_data_r[1:0];
               end
            end else if (aw_addr_r[3:2] == tcd_pkg::OFF_STATUS[3:2] ||
                         aw_addr_r[3:2] == tcd_pkg::OFF_SLOW_THR[3:2] ||
                         aw_addr_r[3:2] == tcd_pkg::OFF_DAC[3:2]) begin
               s_axi_bresp <= tcd_pkg::RESP_OKAY;
            end else begin
               s_axi_bresp <= tcd_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr[3:2])
         tcd_pkg::OFF_CTRL[3:2]: begin
            rd_word[1:0] = ctrl_r;
         end
         tcd_pkg::OFF_STATUS[3:2]: begin
            rd_word[tcd_pkg::ST_ERR_BIT] = err_r;
            rd_word[tcd_pkg::ST_BUSY_BIT] = busy_r;
            rd_word[tcd_pkg::ST_STREAM_BIT] = stream_on_r;
            rd_word[tcd_pkg::ST_KIND_LSB +: 2] = stream_kind_r;
            rd_word[tcd_pkg::ST_WE_SINGLE_BIT] = we_single_r;
            rd_word[tcd_pkg::ST_WE_CONT_BIT] = we_cont_r;
            rd_word[tcd_pkg::ST_AE_SINGLE_BIT] = ae_single_r;
            rd_word[tcd_pkg::ST_AE_PERS_BIT] = ae_pers_r;
            rd_word[tcd_pkg::ST_AE_CKS_BIT] = ae_cks_r;
            rd_word[tcd_pkg::ST_SRC_BIT] = ram_r[5][0];
            rd_word[tcd_pkg::ST_PWR_MSG_BIT] = ram_r[6][0];
         end
         tcd_pkg::OFF_SLOW_THR[3:2]: begin
            rd_word[15:0] = ram_r[4];
         end
         default: begin
            rd_word[11:0] = dac_r;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= tcd_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= tcd_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : tcd_dispatch

// ==== include/tcd_pkg.sv ====
// Package for the transducer command dispatcher: codes, layouts, offsets, timing.
package tcd_pkg;

   // Register byte offsets on the AXI4-Lite slave
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_SLOW_THR = 4'h8;
   localparam logic [3:0] OFF_DAC = 4'hc;

   // Control register fields and reset value
   localparam int CTRL_CMD_EN_BIT = 0;
   localparam int CTRL_MSG_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

   // Status register field positions
   localparam int ST_ERR_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_STREAM_BIT = 2;
   localparam int ST_KIND_LSB = 3;
   localparam int ST_WE_SINGLE_BIT = 5;
   localparam int ST_WE_CONT_BIT = 6;
   localparam int ST_AE_SINGLE_BIT = 7;
   localparam int ST_AE_PERS_BIT = 8;
   localparam int ST_AE_CKS_BIT = 9;
   localparam int ST_SRC_BIT = 10;
   localparam int ST_PWR_MSG_BIT = 11;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Reset values of RAM and nonvolatile parameters and of the converter level
   localparam logic [15:0] PARAM_RESET = 16'h0000;
   localparam logic [11:0] DAC_RESET = 12'h000;

   // After-type execution time
   localparam int CLK_PERIOD_NS = 10;
   localparam int AFTER_EXEC_NS = 2000;
   localparam int AFTER_EXEC_CYC = (AFTER_EXEC_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   AFTER_EXEC_NS / CLK_PERIOD_NS;
   localparam logic [7:0] AFTER_EXEC_LAST = 8'(AFTER_EXEC_CYC - 1);

   typedef enum logic [4:0] {
      CMD_INIT = 5'h00,
      CMD_INIT_RESET = 5'h01,
      CMD_CONT_P_TXT = 5'h02,
      CMD_CONT_P_BIN = 5'h03,
      CMD_CONT_T_C = 5'h04,
      CMD_CONT_T_F = 5'h05,
      CMD_ANALOG_LEVEL = 5'h06,
      CMD_DAC_BIN = 5'h07,
      CMD_WE = 5'h08,
      CMD_WE_RAM = 5'h09,
      CMD_AE = 5'h0a,
      CMD_AE_PERSIST = 5'h0b,
      CMD_AE_CKS = 5'h0c,
      CMD_STRING = 5'h0d,
      CMD_STORE_ALL = 5'h0e,
      CMD_SRC_SEL = 5'h0f,
      CMD_ANALOG_CFG = 5'h10,
      CMD_POWERUP_MODE = 5'h11,
      CMD_SLOW_THR = 5'h12,
      CMD_READ_STATUS = 5'h13,
      CMD_PARAM_BEFORE = 5'h14,
      CMD_PARAM_AFTER = 5'h15,
      CMD_INFO_AFTER = 5'h16
   } tcd_code_t;

   typedef enum logic [1:0] {
      ORD_NONE = 2'h0,
      ORD_REPLY_FIRST = 2'h1,
      ORD_FWD_FIRST = 2'h2
   } tcd_order_t;

   // Decoded command from the character front end
   typedef struct packed {
      logic valid;
      tcd_code_t code;
      logic action;
      logic multi;
      logic [1:0] sel;
      logic [15:0] value;
      logic cks_ok;
   } tcd_cmd_t;

   // Reply descriptor toward the serial transmitter
   typedef struct packed {
      logic valid;
      tcd_order_t order;
      logic rejected;
      logic [15:0] data;
   } tcd_reply_t;

   // Effects on converter, storage and streams
   typedef struct packed {
      logic dac_wr;
      logic [11:0] dac_val;
      logic stream_start;
      logic stream_stop;
      logic [1:0] stream_kind;
      logic nv_store_all;
      logic nv_restore;
      logic nv_string_wr;
      logic [1:0] string_sel;
      logic [15:0] string_val;
      logic powerup_msg;
   } tcd_fx_t;

endpackage : tcd_pkg

// ==== verification/tcd_asserts.sv ====
// Concurrent checks on the command dispatcher ports.
`timescale 1ns/10ps
module tcd_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input tcd_pkg::tcd_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic powerup_evt,
   input tcd_pkg::tcd_reply_t reply,
   input tcd_pkg::tcd_fx_t fx
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic take;
   assign take = cmd.valid && cmd_ready;
   // Codes that run long and hold the busy window
   function automatic logic aft(input tcd_pkg::tcd_code_t c);
      return c inside {[5'h02:5'h06], 5'h0d, 5'h10, 5'h15, 5'h16};
   endfunction : aft
   init_keep_a: assert property (take && cmd.code == tcd_pkg::CMD_INIT |=>
      fx.stream_stop && !fx.nv_restore && !fx.dac_wr) else $error("init changed state");
   init_restore_a: assert property (take && cmd.code == tcd_pkg::CMD_INIT_RESET |=>
      fx.nv_restore) else $error("reset init did not restore");
   stream_only_a: assert property (take && cmd.code inside {[5'h02:5'h05]} |=>
      reply.rejected || (fx.stream_start && !fx.dac_wr && !fx.nv_store_all &&
      fx.stream_kind == 2'($past(cmd.code[1:0]) + 2'h2))) else $error("bad stream start");
   dac_level_a: assert property (take && cmd.code == tcd_pkg::CMD_DAC_BIN |=>
      reply.rejected || (fx.dac_wr && fx.dac_val == $past(cmd.value[11:0])))
      else $error("converter value wrong");
   fwd_first_a: assert property (take && cmd.multi && cmd.code == tcd_pkg::CMD_INFO_AFTER
      |=> reply.rejected || reply.order == tcd_pkg::ORD_FWD_FIRST) else $error("order wrong");
   busy_reject_a: assert property (take && aft(cmd.code) ##1 reply.valid &&
      !reply.rejected ##1 take && aft(cmd.code) |=> reply.rejected)
      else $error("overlapping command taken");
   reply_first_a: assert property (take && cmd.multi &&
      cmd.code == tcd_pkg::CMD_READ_STATUS |=> reply.order == tcd_pkg::ORD_REPLY_FIRST)
      else $error("status reply order wrong");
   string_nv_a: assert property (take && cmd.action &&
      cmd.code == tcd_pkg::CMD_STRING |=> reply.rejected || fx.nv_string_wr)
      else $error("string not stored");
   no_dac_wr_a: assert property (take && (cmd.code == tcd_pkg::CMD_SRC_SEL ||
      (!cmd.action && cmd.code == tcd_pkg::CMD_ANALOG_CFG)) |=> !fx.dac_wr)
      else $error("converter written");
   reject_clean_a: assert property (reply.valid && reply.rejected |-> !fx.dac_wr &&
      !fx.nv_string_wr && !fx.stream_start && !fx.nv_store_all) else $error("reject had effect");
   cover property (take && cmd.code == tcd_pkg::CMD_DAC_BIN ##1 fx.dac_wr);
   cover property (powerup_evt ##1 fx.powerup_msg);
   cover property (reply.valid && reply.rejected);
endmodule : tcd_asserts

bind tcd_dispatch tcd_asserts chk_i (.sys_clk(sys_clk), .rst(rst), .cmd(cmd),
   .cmd_ready(cmd_ready), .powerup_evt(powerup_evt), .reply(reply), .fx(fx));

// ==== verification/tcd_host.sv ====
// Host on the serial network: takes replies as they come.
`timescale 1ns/10ps
module tcd_host (
   input wire logic sys_clk,
   input wire logic rst,
   input tcd_pkg::tcd_reply_t reply,
   output logic [15:0] seen_r
);
   // Group replies may arrive in any order, so none is enforced
   always_ff @(posedge sys_clk) begin
      if (rst) seen_r <= 16'h0000;
      else if (reply.valid) seen_r <= seen_r + 16'h0001;
   end
endmodule : tcd_host

// ==== verification/tb_top.sv ====
// Self-checking bench for the command dispatcher.
`timescale 1ns/10ps
module tb_top;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   tcd_pkg::tcd_cmd_t cmd = '0;
   logic powerup_evt = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, seed = 32'h22bdd72e;
   logic cmd_ready, awready, wready, bvalid, arready, rvalid, err = 1'h0;
   logic [1:0] bresp, rresp;
   tcd_pkg::tcd_reply_t reply;
   tcd_pkg::tcd_fx_t fx;
   logic [63:0] cq[$], aq[$];
   logic [15:0] thr = 16'h0000;
   logic [11:0] dac = 12'h000;
   logic [15:0] seen;
   int bad_count = 0, tests_run = 0, cyc = 0;
   // Entry: [4:0] code, 5 action, 6 group, 7 refused, 8 long wait, 9 bad checksum
   localparam logic [9:0] SEQ [52] = '{10'h0b2, 10'h013, 10'h013,
      10'h028, 10'h072, 10'h0b2,
      10'h029, 10'h032, 10'h032, 10'h028, 10'h032, 10'h0b2,
      10'h028, 10'h029, 10'h0ad, 10'h028, 10'h12d, 10'h028, 10'h02e,
      10'h0a6, 10'h02a, 10'h166, 10'h0a6, 10'h02b, 10'h126, 10'h126,
      10'h002, 10'h096, 10'h185,
      10'h103, 10'h104, 10'h145, 10'h000, 10'h001, 10'h013,
      10'h02c, 10'h2a7, 10'h027, 10'h027,
      10'h028, 10'h06f, 10'h150, 10'h028, 10'h130,
      10'h028, 10'h071, 10'h028, 10'h034, 10'h028, 10'h135, 10'h156, 10'h053};

   tcd_dispatch uut (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .cmd_ready(cmd_ready),
      .powerup_evt(powerup_evt), .reply(reply), .fx(fx), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   tcd_host host (.sys_clk(sys_clk), .rst(rst), .reply(reply), .seen_r(seen));

   always #5 sys_clk = ~sys_clk;

   function automatic logic [15:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction : xs

   function automatic logic [1:0] ordf(input logic [4:0] k, input logic m);
      if (!m) return tcd_pkg::ORD_NONE;
      if (k inside {5'h0f, [5'h11:5'h14]}) return tcd_pkg::ORD_REPLY_FIRST;
      if (k inside {[5'h02:5'h06], 5'h0d, 5'h10, 5'h15, 5'h16}) return tcd_pkg::ORD_FWD_FIRST;
      return tcd_pkg::ORD_NONE;
   endfunction : ordf

   task automatic chk(input logic [31:0] g, input logic [63:0] n);
      tests_run++;
      if ((g & n[63:32]) !== n[31:0]) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g & n[63:32], n[31:0]);
      end
   endtask : chk

   task automatic snd(input logic [9:0] e);
      logic [15:0] v;
      logic st;
      v = xs();
      st = e[4:0] == tcd_pkg::CMD_READ_STATUS;
      if (e[4:0] == tcd_pkg::CMD_POWERUP_MODE) v[0] = 1'h1;
      @(posedge sys_clk);
      cmd <= '{1'h1, tcd_pkg::tcd_code_t'(e[4:0]), e[5], e[6], v[1:0], v, !e[9]};
      cq.push_back({st ? 32'h0007_0001 : 32'h0007_ffff, 13'h0, ordf(e[4:0], e[6]), e[7],
         st ? {15'h0, err} : v});
      if (st) err = 1'h0;
      if (e[7]) err = 1'h1;
      if (!e[7] && e[4:0] == tcd_pkg::CMD_SLOW_THR) thr = v;
      if (!e[7] && e[4:0] inside {tcd_pkg::CMD_ANALOG_LEVEL, tcd_pkg::CMD_DAC_BIN}) dac = v[11:0];
      // Hold the command until the dispatcher is seen ready at an edge
      do begin
         @(posedge sys_clk);
      end while (!cmd_ready);
      cmd.valid <= 1'h0;
      // Long commands keep the unit busy; let the window close
      if (e[8]) repeat (205) @(posedge sys_clk);
   endtask : snd

   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      aq.push_back({32'h3, 30'h0, tcd_pkg::RESP_OKAY});
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
   endtask : axw

   task automatic axr(input logic [3:0] a, input logic [63:0] n);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      aq.push_back(n);
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
   endtask : axr

   task automatic results();
      if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results

   // An empty queue yields an all-ones note so a stray result cannot pass
   always @(posedge sys_clk) begin
      cyc++;
      if (reply.valid) chk({13'h0, reply.order, reply.rejected, reply.data},
         cq.size() ? cq.pop_front() : {64{1'h1}});
      if (bvalid && bready) chk({30'h0, bresp}, aq.size() ? aq.pop_front() : {64{1'h1}});
      if (rvalid && rready) chk(rdata, aq.size() ? aq.pop_front() : {64{1'h1}});
      if (rvalid && rready) chk({30'h0, rresp}, {32'h3, 30'h0, tcd_pkg::RESP_OKAY});
      if (cyc == 12000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'h0;
      axr(tcd_pkg::OFF_CTRL, {32'h3, 30'h0, tcd_pkg::CTRL_RESET});
      axr(tcd_pkg::OFF_SLOW_THR, {32'hffff, 16'h0, tcd_pkg::PARAM_RESET});
      axr(tcd_pkg::OFF_DAC, {32'hfff, 20'h0, tcd_pkg::DAC_RESET});
      axw(tcd_pkg::OFF_CTRL, 32'h2);
      #1 chk({31'h0, cmd_ready}, {32'h1, 32'h0});
      axw(tcd_pkg::OFF_CTRL, 32'h3);
      foreach (SEQ[i]) snd(SEQ[i]);
      @(posedge sys_clk);
      powerup_evt <= 1'h1;
      @(posedge sys_clk);
      powerup_evt <= 1'h0;
      #1 chk({31'h0, fx.powerup_msg}, {32'h1, 32'h1});
      axr(tcd_pkg::OFF_SLOW_THR, {32'hffff, 16'h0, thr});
      axr(tcd_pkg::OFF_DAC, {32'hfff, 20'h0, dac});
      axr(tcd_pkg::OFF_STATUS, {32'h203, 32'h200});
      chk({16'h0, seen}, {32'hffff, 16'h0, 16'h0034});
      repeat (3) @(posedge sys_clk);
      results();
   end
endmodule : tb_top
